// file: logic/cbri_consts.svh
// Timing counts, field positions and reset values of the bus sequencer.
// Assumes inclusion by bare name from the design files only.
`ifndef CBRI_CONSTS_SVH
`define CBRI_CONSTS_SVH

// Clock cycles per microcycle phase; four phases make one microcycle.
`define CBRI_PHASE_CLKS   1
// Phase indices held by the phase counter.
`define CBRI_PH1          2'h0
`define CBRI_PH2          2'h1
`define CBRI_PH3          2'h2
`define CBRI_PH4          2'h3
// Data chip byte registers and the B field bit that requests read-modify-write.
`define CBRI_NREGS        16
`define CBRI_RMW_BIT      3
// Depth of the receive buffer between the bus and the user side.
`define CBRI_BUF_DEPTH    2
// Reset values of the bus lines and internal data.
`define CBRI_LINE_IDLE_N  1'h1
`define CBRI_WORD_ZERO    16'h0000

`endif

// file: logic/cbri_pkg.sv
// Types shared by the bus sequencer files.
// Assumes nothing of its surroundings.
package cbri_pkg;

    // Microinstruction classes seen by the bus interface.
    typedef enum logic [2:0] {
        CBRI_OP_DATA,
        CBRI_OP_READ,
        CBRI_OP_WRITE,
        CBRI_OP_READ_ACK,
        CBRI_OP_WRITE_ACK,
        CBRI_OP_IN_WORD,
        CBRI_OP_OUT_WORD,
        CBRI_OP_OUT_BYTE
    } cbri_op_t;

endpackage

// file: logic/cbri_buf.sv
// Small shift-register buffer with valid and ready on both sides.
// Assumes one clock and a source that holds its word until accepted.
`timescale 1ns/1ps
`default_nettype none

module cbri_buf #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
) (
    input  wire logic             i_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_valid,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_ready,
    output logic                  o_valid,
    output logic [WIDTH-1:0]      o_data,
    input  wire logic             i_ready
);

    // The head entry is itself a flip-flop, so the read side sees no mux.
    logic [WIDTH-1:0] mem_r [0:DEPTH-1];
    logic [7:0]       cnt_r;
    logic [7:0]       cnt_nxt;
    logic             push;
    logic             pop;
    logic             vld_r;

    assign o_ready = cnt_r < 8'(DEPTH);
    assign push    = i_valid && o_ready;
    assign pop     = vld_r && i_ready;
    assign cnt_nxt = cnt_r + (push ? 8'h01 : 8'h00) - (pop ? 8'h01 : 8'h00);
    assign o_valid = vld_r;
    assign o_data  = mem_r[0];

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= 8'h00;
            vld_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            vld_r <= cnt_nxt != 8'h00;
        end
    end

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : g_ent
            always_ff @(posedge i_clk) begin
                if (push && (8'(g) == (pop ? cnt_r - 8'h01 : cnt_r))) begin
                    mem_r[g] <= i_data;
                end else if (pop && (g < DEPTH - 1)) begin
                    mem_r[g] <= mem_r[(g < DEPTH - 1) ? g + 1 : g];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// file: logic/cbri_bus_seq.sv
// Processor-side system bus interface: reply, strobe, sync and interrupt
// acknowledge logic driven by microinstructions on a four-phase microcycle.
// Assumes bus pins arrive asynchronously and the microinstruction source
// holds I_MI_VALID and its fields until O_MI_DONE.
`include "cbri_consts.svh"
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Reply flip-flop samples the bus reply only at the start of phase 1.
// - Input and output operations test synchronised reply at phase 3, waiting until it passes.
// - Input word stores low byte first, then high byte into register A with bit0 inverted.
// - Read-modify-write input completion drops input request and strobe, keeps sync request.
// - Dropping the input request cancels the synchronised reply immediately.
// - After failed output check, output request rises at phase 1, strobe at phase 3.
// - Output byte asserts write-byte for one microcycle from phase 1; word never.
// - Output drives both data bytes as one word onto the address/data lines.
// - Reply set during output resets the output strobe at phase 3, cancelling reply.
// - Negated bus reply resets the reply flip-flop at phase 1, ending busy.
// - After output: sync request drops phase 2, output request phase 4, data removed.
// - Data manipulation operations never test reply or busy and never wait.
// - Read-acknowledge completes in its first microcycle when idle, changing no bus line.
// - Interrupt acknowledge drives the designated registers onto the lines at phase 1.
// - Acknowledge asserts sync and acknowledge requests at phase 2; bus sync stays suppressed.
// - Next microcycle the input request and input strobe assert at phase 2.
// - Interrupt acknowledge flip-flop is locked reset until input request, then sets.
// - Write-acknowledge never drives bus interrupt acknowledge.
// - B field argument marks read-modify-write; transfer ends only after output completes.
// - Read or write group operations wait while the reply flip-flop stays set.
module cbri_bus_seq #(
    parameter int PHASE_CLKS = `CBRI_PHASE_CLKS,
    parameter int BUF_DEPTH  = `CBRI_BUF_DEPTH
) (
    input  wire logic              I_CLK,
    input  wire logic              I_RSTN,
    input  wire logic              I_MI_VALID,
    input  wire cbri_pkg::cbri_op_t I_MI_OP,
    input  wire logic [3:0]        I_MI_A,
    input  wire logic [3:0]        I_MI_B,
    input  wire logic [15:0]       I_MI_DATA,
    output logic                   O_MI_DONE,
    output logic                   O_MI_WAIT,
    input  wire logic              I_BUS_REPLY_N,
    input  wire logic [15:0]       I_BUS_ADDR_DATA_LINES,
    output logic [15:0]            O_BUS_ADDR_DATA_LINES,
    output logic                   O_BUS_ADDR_DATA_LINES_OE,
    output logic                   O_BUS_SYNC_N,
    output logic                   O_BUS_INPUT_STROBE_N,
    output logic                   O_BUS_OUTPUT_STROBE_N,
    output logic                   O_BUS_WRITE_BYTE_N,
    output logic                   O_BUS_INT_ACKNOWLEDGE,
    output logic                   O_BUSY,
    output logic                   O_RX_VALID,
    output logic [15:0]            O_RX_DATA,
    input  wire logic              I_RX_READY
);

    localparam logic [7:0] DIV_LAST = 8'(PHASE_CLKS - 1);

    // ==========================================================
    // Phase generator
    logic [7:0] div_r;
    logic [1:0] ph_r;
    logic [1:0] ph_next;
    logic       tick;
    logic       st1;
    logic       st2;
    logic       st3;
    logic       st4;

    assign tick    = div_r == DIV_LAST;
    assign ph_next = ph_r + 2'h1;
    assign st1     = tick && (ph_next == `CBRI_PH1);
    assign st2     = tick && (ph_next == `CBRI_PH2);
    assign st3     = tick && (ph_next == `CBRI_PH3);
    assign st4     = tick && (ph_next == `CBRI_PH4);

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            div_r <= 8'h00;
            ph_r  <= `CBRI_PH4;
        end else begin
            div_r <= tick ? 8'h00 : div_r + 8'h01;
            ph_r  <= tick ? ph_next : ph_r;
        end
    end

    // ==========================================================
    // Pin synchronisers
    logic        rply_s1_r;
    logic        rply_s2_r;
    logic [15:0] dal_s1_r;
    logic [15:0] dal_s2_r;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            rply_s1_r <= `CBRI_LINE_IDLE_N;
            rply_s2_r <= `CBRI_LINE_IDLE_N;
            dal_s1_r  <= `CBRI_WORD_ZERO;
            dal_s2_r  <= `CBRI_WORD_ZERO;
        end else begin
            rply_s1_r <= I_BUS_REPLY_N;
            rply_s2_r <= rply_s1_r;
            dal_s1_r  <= I_BUS_ADDR_DATA_LINES;
            dal_s2_r  <= dal_s1_r;
        end
    end

    // ==========================================================
    // Sequencer state and decode
    logic               run_r;
    cbri_pkg::cbri_op_t op_r;
    logic [3:0]         a_r;
    logic               rmw_r;
    logic               first_r;
    logic               low_done_r;
    logic [7:0]         op_cyc_r;
    logic               reply_ff;
    logic               dout_n_r;
    logic               sync_n_r;
    logic               iack_r;
    logic               wb_n_r;
    logic               input_req;
    logic               output_req;
    logic               sync_req;
    logic               ack_req;
    logic               buf_ready;
    logic               reply_h;
    logic               rw_group;
    logic               io_group;
    logic               is_out;
    logic               take;
    logic               pass;
    logic               done;
    logic               low_step;
    logic               high_step;
    logic               push;

    // Reply as seen by the sequencer only exists while a strobe request is live.
    assign reply_h   = reply_ff && (input_req || !dout_n_r);
    assign is_out    = (op_r == cbri_pkg::CBRI_OP_OUT_WORD) || (op_r == cbri_pkg::CBRI_OP_OUT_BYTE);
    assign rw_group  = (op_r == cbri_pkg::CBRI_OP_READ) || (op_r == cbri_pkg::CBRI_OP_WRITE)
                     || (op_r == cbri_pkg::CBRI_OP_READ_ACK)
                     || (op_r == cbri_pkg::CBRI_OP_WRITE_ACK);
    assign io_group  = is_out || (op_r == cbri_pkg::CBRI_OP_IN_WORD);
    assign take      = st1 && !run_r && I_MI_VALID;
    // A high byte with no room in the buffer waits rather than lose the word.
    assign low_step  = (op_r == cbri_pkg::CBRI_OP_IN_WORD) && reply_h && !low_done_r;
    assign high_step = (op_r == cbri_pkg::CBRI_OP_IN_WORD) && reply_h && low_done_r
                     && buf_ready;
    assign pass      = (op_r == cbri_pkg::CBRI_OP_DATA)
                     || (rw_group && !reply_ff && !reply_h)
                     || high_step
                     || (is_out && reply_h);
    assign done      = run_r && st3 && pass;
    assign push      = run_r && st3 && high_step;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            run_r      <= 1'b0;
            op_r       <= cbri_pkg::CBRI_OP_DATA;
            a_r        <= 4'h0;
            rmw_r      <= 1'b0;
            first_r    <= 1'b0;
            low_done_r <= 1'b0;
        end else if (take) begin
            run_r      <= 1'b1;
            op_r       <= I_MI_OP;
            a_r        <= I_MI_A;
            rmw_r      <= (I_MI_OP == cbri_pkg::CBRI_OP_IN_WORD) ? I_MI_B[`CBRI_RMW_BIT] : rmw_r;
            first_r    <= 1'b1;
            low_done_r <= 1'b0;
        end else if (run_r && st3) begin
            run_r      <= !pass;
            first_r    <= 1'b0;
            low_done_r <= low_done_r || low_step;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_MI_DONE <= 1'b0;
            O_MI_WAIT <= 1'b0;
            op_cyc_r  <= 8'h00;
        end else begin
            O_MI_DONE <= done;
            O_MI_WAIT <= run_r && (st3 ? !pass : O_MI_WAIT);
            op_cyc_r  <= take ? 8'h00 : ((run_r && st1) ? op_cyc_r + 8'h01 : op_cyc_r);
        end
    end

    // ==========================================================
    // Byte register file
    logic [7:0] regs [0:`CBRI_NREGS-1];
    logic [3:0] a_pair;

    assign a_pair = a_r ^ 4'h1;

    always_ff @(posedge I_CLK) begin
        if (done && (op_r == cbri_pkg::CBRI_OP_DATA)) begin
            regs[a_r]    <= I_MI_DATA[7:0];
            regs[a_pair] <= I_MI_DATA[15:8];
        end else if (run_r && st3 && low_step) begin
            regs[a_r]    <= dal_s2_r[7:0];
        end else if (push) begin
            regs[a_pair] <= dal_s2_r[15:8];
        end
    end

    // ==========================================================
    // Transfer scheduling
    logic addr_pend_r;
    logic addr_cyc_r;
    logic rd_r;
    logic ak_r;
    logic din_arm_r;
    logic in_end_r;
    logic out_arm_r;
    logic out_end_r;
    logic out_rel_r;
    logic out_byte_r;

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            addr_pend_r <= 1'b0;
            rd_r        <= 1'b0;
            ak_r        <= 1'b0;
            out_arm_r   <= 1'b0;
            out_byte_r  <= 1'b0;
        end else if (done && rw_group) begin
            addr_pend_r <= 1'b1;
            rd_r        <= (op_r == cbri_pkg::CBRI_OP_READ) || (op_r == cbri_pkg::CBRI_OP_READ_ACK);
            ak_r        <= (op_r == cbri_pkg::CBRI_OP_READ_ACK)
                        || (op_r == cbri_pkg::CBRI_OP_WRITE_ACK);
        end else if (run_r && st3 && is_out && first_r && !pass) begin
            out_arm_r   <= 1'b1;
            out_byte_r  <= op_r == cbri_pkg::CBRI_OP_OUT_BYTE;
        end else if (st1) begin
            addr_pend_r <= 1'b0;
            out_arm_r   <= 1'b0;
        end
    end

    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            addr_cyc_r <= 1'b0;
            din_arm_r  <= 1'b0;
            in_end_r   <= 1'b0;
            out_end_r  <= 1'b0;
            out_rel_r  <= 1'b0;
        end else begin
            if (st1) begin
                addr_cyc_r <= addr_pend_r;
            end
            if (st2) begin
                din_arm_r <= addr_cyc_r && rd_r;
                in_end_r  <= 1'b0;
            end else if (push) begin
                in_end_r  <= 1'b1;
            end
            // Completion is held over to the next microcycle, whose phases close the transfer.
            if (done && is_out) begin
                out_rel_r <= 1'b1;
            end else if (st1) begin
                out_rel_r <= 1'b0;
            end
            if (st1) begin
                out_end_r <= out_rel_r;
            end
        end
    end

    // ==========================================================
    // Request lines
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sync_req   <= 1'b0;
            ack_req    <= 1'b0;
            input_req  <= 1'b0;
            output_req <= 1'b0;
        end else begin
            if (st2 && addr_cyc_r) begin
                sync_req <= 1'b1;
                ack_req  <= ak_r;
            end else if (st2 && (in_end_r || out_end_r)) begin
                sync_req <= in_end_r && rmw_r;
                ack_req  <= 1'b0;
            end
            if (st2 && din_arm_r) begin
                input_req <= 1'b1;
            end else if (st2 && in_end_r) begin
                input_req <= 1'b0;
            end
            if (st1 && out_arm_r) begin
                output_req <= 1'b1;
            end else if (st4 && out_end_r) begin
                output_req <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Bus flip-flops
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            reply_ff <= 1'b0;
            dout_n_r <= `CBRI_LINE_IDLE_N;
            sync_n_r <= `CBRI_LINE_IDLE_N;
            iack_r   <= 1'b0;
            wb_n_r   <= `CBRI_LINE_IDLE_N;
        end else begin
            if (st1) begin
                reply_ff <= !rply_s2_r;
                wb_n_r   <= !(out_arm_r && out_byte_r);
            end
            if (st3) begin
                dout_n_r <= !(output_req && !reply_ff);
            end
            if (ack_req) begin
                sync_n_r <= `CBRI_LINE_IDLE_N;
            end else if (st4) begin
                sync_n_r <= !(sync_req || (!sync_n_r && reply_ff));
            end
            if (!input_req || !ack_req) begin
                iack_r <= 1'b0;
            end else if (st2) begin
                iack_r <= 1'b1;
            end
        end
    end

    // The input strobe follows its request within the same edge.
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_BUS_INPUT_STROBE_N <= `CBRI_LINE_IDLE_N;
        end else if (st2) begin
            O_BUS_INPUT_STROBE_N <= !((din_arm_r || input_req) && !in_end_r);
        end
    end

    // ==========================================================
    // Address/data drive
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_BUS_ADDR_DATA_LINES    <= `CBRI_WORD_ZERO;
            O_BUS_ADDR_DATA_LINES_OE <= 1'b0;
        end else if (st1 && (addr_pend_r || out_arm_r)) begin
            O_BUS_ADDR_DATA_LINES    <= {regs[a_pair], regs[a_r]};
            O_BUS_ADDR_DATA_LINES_OE <= 1'b1;
        end else if ((st4 && addr_cyc_r) || (st1 && out_end_r)) begin
            O_BUS_ADDR_DATA_LINES_OE <= 1'b0;
        end
    end

    assign O_BUS_SYNC_N          = sync_n_r;
    assign O_BUS_OUTPUT_STROBE_N = dout_n_r;
    assign O_BUS_WRITE_BYTE_N    = wb_n_r;
    assign O_BUS_INT_ACKNOWLEDGE = iack_r;
    assign O_BUSY                = reply_ff;

    cbri_buf #(
        .WIDTH (16),
        .DEPTH (BUF_DEPTH)
    ) u_rx_buf (
        .i_clk   (I_CLK),
        .i_rstn  (I_RSTN),
        .i_valid (push),
        .i_data  ({dal_s2_r[15:8], regs[a_r]}),
        .o_ready (buf_ready),
        .o_valid (O_RX_VALID),
        .o_data  (O_RX_DATA),
        .i_ready (I_RX_READY)
    );

    // ==========================================================
    // Assertions
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RSTN);

    sequence s_out_fail;
        run_r && st3 && is_out && first_r && !reply_h;
    endsequence

    sequence s_reply_in_out;
        st3 && reply_ff && !dout_n_r;
    endsequence

    a_reply_phase1: assert property ($changed(reply_ff) |-> $past(st1))
        else $error("reply flip-flop moved outside phase 1");
    a_io_wait: assert property (run_r && io_group && st3 && !reply_h |=> O_MI_WAIT && run_r)
        else $error("failed reply check did not wait");
    a_reply_cancel: assert property ($fell(input_req) && dout_n_r |-> !reply_h)
        else $error("reply seen after input request dropped");
    a_out_arm: assert property (s_out_fail |=> out_arm_r)
        else $error("failed output check did not arm output request");
    a_strobe_ph3: assert property ($fell(dout_n_r) |-> $past(st3 && output_req))
        else $error("output strobe asserted off phase 3");
    a_wb_phase1: assert property ($changed(wb_n_r) |-> $past(st1))
        else $error("write-byte changed off phase 1");
    a_out_drive: assert property (output_req && !out_end_r |-> O_BUS_ADDR_DATA_LINES_OE)
        else $error("output word not driven");
    a_strobe_drop: assert property (s_reply_in_out |=> dout_n_r && !reply_h)
        else $error("output strobe not reset after reply");
    a_data_nowait: assert property (O_MI_DONE && op_r == cbri_pkg::CBRI_OP_DATA |-> op_cyc_r == 8'h00)
        else $error("data operation waited");
    a_busy_gate: assert property (done && rw_group |-> !reply_ff)
        else $error("read or write group completed while busy");
    a_sync_block: assert property (ack_req && $past(ack_req) |-> sync_n_r)
        else $error("bus sync asserted during acknowledge");
    a_iack_lock: assert property ($rose(iack_r) |-> $past(st2 && input_req && ack_req))
        else $error("acknowledge set without input request");

endmodule

`default_nettype wire

// file: verif/cbri_periph.sv
// Behavioural model of the addressed or interrupting device on the system bus.
// Assumes active-low strobes and reply, and a bench that resolves the shared lines.
`timescale 1ns/1ps
`default_nettype none

module cbri_periph #(
    // Interrupt vector; the value is arbitrary.
    parameter logic [15:0] VEC = 16'h00c8
) (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic [2:0]  i_delay,
    input  wire logic        i_sync_n,
    input  wire logic        i_in_n,
    input  wire logic        i_out_n,
    input  wire logic        i_iack,
    input  wire logic [15:0] i_lines,
    output logic             o_reply_n,
    output logic [15:0]      o_data,
    output logic             o_wr,
    output logic [15:0]      o_wr_data
);
    // ==========================================================
    // Request decode
    logic [15:0] mem_r;
    logic [15:0] val_r;
    logic [15:0] last_r;
    logic [2:0]  cnt_r;
    logic        drive_r;
    wire         rd_req = !i_in_n && (i_iack || !i_sync_n);
    wire         wr_req = !i_out_n && !i_sync_n;
    // Released lines show the inverse of the last value, so stale data never looks valid.
    assign o_data = drive_r ? val_r : ~last_r;

    // ==========================================================
    // Reply with a programmable delay
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reply_n <= 1'b1;
            cnt_r     <= 3'h0;
            drive_r   <= 1'b0;
            mem_r     <= 16'h0000;
            val_r     <= 16'h0000;
            last_r    <= 16'h0000;
            o_wr      <= 1'b0;
            o_wr_data <= 16'h0000;
        end else begin
            if (drive_r) begin
                last_r <= val_r;
            end
            o_wr   <= 1'b0;
            if (!(rd_req || wr_req)) begin
                cnt_r     <= 3'h0;
                o_reply_n <= 1'b1;
                drive_r   <= 1'b0;
            end else if (cnt_r != i_delay) begin
                cnt_r <= cnt_r + 3'h1;
            end else if (o_reply_n) begin
                o_reply_n <= 1'b0;
                drive_r   <= rd_req;
                val_r     <= i_iack ? VEC : mem_r;
                if (wr_req) begin
                    mem_r     <= i_lines;
                    o_wr      <= 1'b1;
                    o_wr_data <= i_lines;
                end
            end
        end
    end
endmodule

`default_nettype wire

// file: verif/cpu_bus_rmw_and_intack_logic_bench.sv
// Self-checking bench of the bus sequencer against a queue model.
// Assumes the device model cbri_periph on the far side of the bus.
`timescale 1ns/1ps
`default_nettype none

module cpu_bus_rmw_and_intack_logic_bench;
    localparam logic [15:0] VEC = 16'h00c8;
    logic               clk = 1'b0;
    logic               rstn = 1'b0;
    logic               mi_valid = 1'b0;
    cbri_pkg::cbri_op_t mi_op = cbri_pkg::CBRI_OP_DATA;
    logic [3:0]         mi_a = 4'h0;
    logic [3:0]         mi_b = 4'h0;
    logic [15:0]        mi_data = 16'h0000;
    logic               rx_ready = 1'b0;
    logic               hold = 1'b0;
    logic [2:0]         dly = 3'h0;
    logic               saw_wb, saw_iack, saw_sync, saw_wait;
    logic [15:0]        mem_m = 16'h0000;
    logic [15:0]        exp_rx[$];
    logic [15:0]        exp_wr[$];
    int                 n_fail = 0;
    int                 n_compared = 0;
    int                 seed = 32'h9ef2;
    wire logic          done, wait_o, reply_n, oe, sync_n, in_n, out_n, wb_n, iack;
    wire logic          rx_valid, wr_stb, busy;
    wire logic [15:0]   dout, p_data, rx_data, wr_data;
    wire logic [15:0]   lines = oe ? dout : p_data;

    always #25 clk = ~clk;

    cbri_bus_seq u_cbri_bus_seq (.I_CLK(clk), .I_RSTN(rstn), .I_MI_VALID(mi_valid),
        .I_MI_OP(mi_op), .I_MI_A(mi_a), .I_MI_B(mi_b), .I_MI_DATA(mi_data),
        .O_MI_DONE(done), .O_MI_WAIT(wait_o), .I_BUS_REPLY_N(reply_n),
        .I_BUS_ADDR_DATA_LINES(lines), .O_BUS_ADDR_DATA_LINES(dout),
        .O_BUS_ADDR_DATA_LINES_OE(oe), .O_BUS_SYNC_N(sync_n), .O_BUS_INPUT_STROBE_N(in_n),
        .O_BUS_OUTPUT_STROBE_N(out_n), .O_BUS_WRITE_BYTE_N(wb_n),
        .O_BUS_INT_ACKNOWLEDGE(iack), .O_BUSY(busy), .O_RX_VALID(rx_valid),
        .O_RX_DATA(rx_data), .I_RX_READY(rx_ready));
    cbri_periph #(.VEC(VEC)) u_cbri_periph (.i_clk(clk), .i_rstn(rstn), .i_delay(dly),
        .i_sync_n(sync_n), .i_in_n(in_n), .i_out_n(out_n), .i_iack(iack), .i_lines(lines),
        .o_reply_n(reply_n), .o_data(p_data), .o_wr(wr_stb), .o_wr_data(wr_data));

    // ==========================================================
    // Comparison and closing
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // ==========================================================
    // Monitor: every received and every written word meets the model.
    always @(posedge clk) begin
        if (rx_valid === 1'b1 && rx_ready) check("rx word", rx_data, exp_rx.size() ? exp_rx.pop_front() : 16'hxxxx);
        if (wr_stb === 1'b1) check("bus word", wr_data, exp_wr.size() ? exp_wr.pop_front() : 16'hxxxx);
        if (wb_n === 1'b0) saw_wb = 1'b1;
        if (iack === 1'b1) saw_iack = 1'b1;
        if (sync_n === 1'b0) saw_sync = 1'b1;
        if (wait_o === 1'b1) saw_wait = 1'b1;
        rx_ready <= !hold && ($random(seed) % 2 != 0);
    end

    // ==========================================================
    // Fields change just after a rising edge and hold until done is seen at an edge.
    task automatic op(input cbri_pkg::cbri_op_t o, input logic [3:0] a, input logic [3:0] b,
                      input logic [15:0] d);
        int k;
        mi_op    <= o;
        mi_a     <= a;
        mi_b     <= b;
        mi_data  <= d;
        mi_valid <= 1'b1;
        k        = 0;
        do begin
            @(posedge clk);
            k++;
        end while (done !== 1'b1 && k < 400);
        if (k >= 400) begin
            n_fail++;
            $display("MISMATCH op done expected 1 seen 0");
            summarize();
        end
    endtask
    task automatic read_modify_write_xfer(input logic byte_op);
        logic [15:0] nw;
        nw = 16'($random(seed));
        op(cbri_pkg::CBRI_OP_DATA, 4'h0, 4'h0, 16'($random(seed)));
        op(cbri_pkg::CBRI_OP_READ, 4'h0, 4'h0, 16'h0000);
        exp_rx.push_back(mem_m);
        op(cbri_pkg::CBRI_OP_IN_WORD, 4'h2, 4'h8, 16'h0000);
        check("sync after input", 16'(sync_n), 16'h0000);
        saw_wait = 1'b0;
        op(cbri_pkg::CBRI_OP_DATA, 4'h4, 4'h0, nw);
        check("wait on data op", 16'(saw_wait), 16'h0000);
        check("input strobe", 16'(in_n), 16'h0001);
        check("sync kept", 16'(sync_n), 16'h0000);
        saw_wb = 1'b0;
        exp_wr.push_back(nw);
        op(byte_op ? cbri_pkg::CBRI_OP_OUT_BYTE : cbri_pkg::CBRI_OP_OUT_WORD, 4'h4, 4'h0, 16'h0000);
        mem_m = nw;
        check("write byte seen", 16'(saw_wb), 16'(byte_op));
    endtask
    // Two data microcycles let the last reply drain, so busy is clear for the acknowledge.
    task automatic intr;
        op(cbri_pkg::CBRI_OP_DATA, 4'h6, 4'h0, 16'h0000);
        op(cbri_pkg::CBRI_OP_DATA, 4'h6, 4'h0, 16'h0000);
        saw_wait = 1'b0;
        op(cbri_pkg::CBRI_OP_READ_ACK, 4'h6, 4'h0, 16'h0000);
        check("wait on read ack", 16'(saw_wait), 16'h0000);
        check("busy after read ack", 16'(busy), 16'h0000);
        saw_iack = 1'b0;
        saw_sync = 1'b0;
        exp_rx.push_back(VEC);
        op(cbri_pkg::CBRI_OP_IN_WORD, 4'h8, 4'h0, 16'h0000);
        check("acknowledge seen", 16'(saw_iack), 16'h0001);
        check("sync on acknowledge", 16'(saw_sync), 16'h0000);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            dly <= 3'($random(seed) & 3);
            read_modify_write_xfer(i[0]);
        end
        hold <= 1'b1;
        intr();
        intr();
        hold <= 1'b0;
        mi_valid <= 1'b0;
        repeat (40) @(posedge clk);
        check("rx words left", 16'(exp_rx.size()), 16'h0000);
        check("bus words left", 16'(exp_wr.size()), 16'h0000);
        saw_iack = 1'b0;
        op(cbri_pkg::CBRI_OP_WRITE_ACK, 4'h0, 4'h0, 16'h0000);
        mi_valid <= 1'b0;
        repeat (12) @(posedge clk);
        check("acknowledge on write ack", 16'(saw_iack), 16'h0000);
        summarize();
    end
endmodule

`default_nettype wire
